// ### pcss_pkg.sv
// Shared constants and types for the socket interface status bank
package pcss_pkg;
  localparam int SOCKETS = 2;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_STATUS_A = 12'h801;
  localparam logic [ADDR_W-1:0] OFS_STATUS_B = 12'h841;
  localparam logic [5:0] BANK_BASE = OFS_STATUS_A[11:6];
  localparam logic [5:0] SOCK_B_BASE = OFS_STATUS_B[11:6];
  localparam logic [5:0] LOC_STATUS = OFS_STATUS_A[5:0];
  localparam logic [5:0] LOC_PWR = 6'h02;
  localparam logic [2:0] LOC_WIN_HI = 3'h5;
  localparam int NUM_WIN = 5;
  localparam int WIN_IDX_W = 3;
  localparam int WIN_IDX_LSB = 3;
  localparam int WIN_WP_BIT = 7;
  localparam int BIT_UNUSED_TOP = 7;
  localparam int BIT_PWR = 6;
  localparam int BIT_READY = 5;
  localparam int BIT_WP = 4;
  localparam int BIT_CD2 = 3;
  localparam int BIT_CD1 = 2;
  localparam int BIT_BVD2 = 1;
  localparam int BIT_BVD1 = 0;
  localparam int PIN_W = 6;
  localparam int PIN_READY = 0;
  localparam int PIN_WP = 1;
  localparam int PIN_CD1N = 2;
  localparam int PIN_CD2N = 3;
  localparam int PIN_BVD1 = 4;
  localparam int PIN_BVD2 = 5;
  localparam int SYNC_STAGES = 2;
  localparam int VCC_MSB = 4;
  localparam int VCC_LSB = 3;
  localparam logic [1:0] VCC_OFF = 2'h0;
  localparam logic [1:0] VCC_5V = 2'h2;
  localparam logic [1:0] VCC_3V3 = 2'h3;
  localparam logic [DATA_W-1:0] PWR_WR_MASK = 8'h9B;
  localparam logic [DATA_W-1:0] REG_RST = 8'h00;
  localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;
  typedef enum logic [1:0] {KIND_NONE, KIND_STATUS, KIND_PWR, KIND_WIN} pcss_kind_e;
endpackage

// ### pcss_win_if.sv
// Carrier between the decode logic and one socket's window byte bank
`timescale 1ns/1ps
interface pcss_win_if #(parameter int NWIN = pcss_pkg::NUM_WIN);
  logic wr_en;
  logic [pcss_pkg::WIN_IDX_W-1:0] wr_idx;
  logic [pcss_pkg::DATA_W-1:0] wr_data;
  logic [pcss_pkg::WIN_IDX_W-1:0] rd_idx;
  logic [pcss_pkg::DATA_W-1:0] rd_data;
  logic [NWIN-1:0] wp_vec;
  modport bank (input wr_en, wr_idx, wr_data, rd_idx, output rd_data, wp_vec);
  modport ctrl (output wr_en, wr_idx, wr_data, rd_idx, input rd_data, wp_vec);
endinterface

// ### pcss_sync.sv
// Multi-stage level synchronizer
`timescale 1ns/1ps
module pcss_sync #(
  parameter int WIDTH = 1,
  parameter int STAGES = pcss_pkg::SYNC_STAGES
) (
  input wire logic mclk,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  import pcss_pkg::*;
  logic [WIDTH-1:0] stage_q [STAGES];
  logic [WIDTH-1:0] stage_d [STAGES];

  if (WIDTH < 1 || STAGES < 2) begin : g_bad_cfg
    $error("pcss_sync: unsupported parameters");
  end

  // First stage feeds only the second
  always_comb begin
    stage_d[0] = din;
    for (int i = 1; i < STAGES; i++) begin
      stage_d[i] = stage_q[i-1];
    end
  end

  always_ff @(posedge mclk) begin
    stage_q <= stage_d;
  end

  assign dout = stage_q[STAGES-1];
endmodule

// ### pcss_win_bank.sv
// Memory window high offset bytes of one socket
`timescale 1ns/1ps
module pcss_win_bank #(
  parameter int NWIN = pcss_pkg::NUM_WIN
) (
  input wire logic mclk,
  input wire logic rst,
  pcss_win_if.bank bus
);
  import pcss_pkg::*;
  logic [DATA_W-1:0] mem_q [NWIN];
  logic [DATA_W-1:0] mem_d [NWIN];
  logic [DATA_W-1:0] rd_q;
  logic [DATA_W-1:0] rd_d;

  if (NWIN < 1 || NWIN > (1 << WIN_IDX_W)) begin : g_bad_cfg
    $error("pcss_win_bank: unsupported window count");
  end

  always_comb begin
    mem_d = mem_q;
    rd_d = RD_UNMAPPED;
    if (bus.wr_en && int'(bus.wr_idx) < NWIN) begin
      mem_d[bus.wr_idx] = bus.wr_data;
    end
    if (int'(bus.rd_idx) < NWIN) begin
      rd_d = mem_q[bus.rd_idx];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_q <= '{default: REG_RST};
      rd_q <= REG_RST;
    end else begin
      mem_q <= mem_d;
      rd_q <= rd_d;
    end
  end

  assign bus.rd_data = rd_q;
  for (genvar w = 0; w < NWIN; w++) begin : g_wp
    assign bus.wp_vec[w] = mem_q[w][WIN_WP_BIT];
  end
endmodule

// ### pcss_status_top.sv
// Socket interface status registers for two 16-bit card sockets
`timescale 1ns/1ps
// Behaviour
// - Top status bit always reads zero; writes to it are ignored.
// - Status register read-only; after reset top bits zero, low six live.
// - Two independent status copies: first socket at 01h, second at 41h.
// - Bit 6 shows socket power, set while programmed supply is switched on.
// - Bit 5 follows the card ready pin.
// - Bit 4 follows the write protect pin level directly.
// - Protect bit in a window high offset byte blocks writes through it.
// - Bit 3 is the inverse of the second card detect pin.
// - Bit 2 is the inverse of the first card detect pin.
// - Memory card: bit 0 follows BVD1, bit 1 follows BVD2.
// - I/O card: bit 1 follows speaker, bit 0 follows status change.
module pcss_status_top #(
  parameter int NWIN = pcss_pkg::NUM_WIN
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [pcss_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pcss_pkg::DATA_W-1:0] reg_wdata,
  output logic [pcss_pkg::DATA_W-1:0] reg_rdata_q,
  output logic reg_ack_q,
  input wire logic [pcss_pkg::SOCKETS-1:0] card_ready,
  input wire logic [pcss_pkg::SOCKETS-1:0] card_wp,
  input wire logic [pcss_pkg::SOCKETS-1:0] card_cd1_n,
  input wire logic [pcss_pkg::SOCKETS-1:0] card_cd2_n,
  input wire logic [pcss_pkg::SOCKETS-1:0] card_bvd1,
  input wire logic [pcss_pkg::SOCKETS-1:0] card_bvd2,
  input wire logic mem_wr_req,
  input wire logic mem_wr_sock,
  input wire logic [pcss_pkg::WIN_IDX_W-1:0] mem_wr_win,
  output logic mem_wr_ok_q,
  output logic mem_wr_blocked_q,
  output logic [pcss_pkg::SOCKETS-1:0] socket_power_on_flag_q
);
  import pcss_pkg::*;

  localparam logic [ADDR_W-1:0] PWR_A = {BANK_BASE, LOC_PWR};
  localparam logic [ADDR_W-1:0] WIN0_HI_A = {BANK_BASE, 3'h0, LOC_WIN_HI};

  logic [SOCKETS-1:0][PIN_W-1:0] pin_raw;
  logic [SOCKETS-1:0][PIN_W-1:0] pin_sync;
  logic [SOCKETS-1:0][DATA_W-1:0] status_byte;
  logic [SOCKETS-1:0][DATA_W-1:0] pwr_q;
  logic [SOCKETS-1:0][DATA_W-1:0] pwr_d;
  logic [SOCKETS-1:0] pwr_on_d;
  logic [SOCKETS-1:0][DATA_W-1:0] win_rd;
  logic [SOCKETS-1:0][NWIN-1:0] wp_all;
  logic dec_hit;
  logic dec_sock;
  logic [5:0] dec_loc;
  pcss_kind_e dec_kind;
  logic p1_valid_q;
  logic p1_valid_d;
  logic p1_rd_q;
  logic p1_rd_d;
  pcss_kind_e p1_kind_q;
  pcss_kind_e p1_kind_d;
  logic p1_sock_q;
  logic p1_sock_d;
  logic [DATA_W-1:0] p1_stat_q;
  logic [DATA_W-1:0] p1_stat_d;
  logic [DATA_W-1:0] p1_pwr_q;
  logic [DATA_W-1:0] p1_pwr_d;
  logic [DATA_W-1:0] rdata_d;
  logic ack_d;
  logic win_ok;
  logic win_wp;
  logic mem_ok_d;
  logic mem_blk_d;

  if (SOCKETS != 2 || NWIN < 1 || NWIN > (1 << WIN_IDX_W)) begin : g_bad_cfg
    $error("pcss_status_top: unsupported configuration");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Socket pins into the register clock domain

  // BVD lines double as STSCHG (bit 0) and SPKR (bit 1) on I/O cards
  always_comb begin
    for (int s = 0; s < SOCKETS; s++) begin
      pin_raw[s][PIN_READY] = card_ready[s];
      pin_raw[s][PIN_WP] = card_wp[s];
      pin_raw[s][PIN_CD1N] = card_cd1_n[s];
      pin_raw[s][PIN_CD2N] = card_cd2_n[s];
      pin_raw[s][PIN_BVD1] = card_bvd1[s];
      pin_raw[s][PIN_BVD2] = card_bvd2[s];
    end
  end

  pcss_sync #(
    .WIDTH(SOCKETS * PIN_W),
    .STAGES(SYNC_STAGES)
  ) u_pin_sync (
    .mclk(mclk),
    .din(pin_raw),
    .dout(pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Live status byte, one per socket

  always_comb begin
    for (int s = 0; s < SOCKETS; s++) begin
      status_byte[s] = REG_RST;
      status_byte[s][BIT_UNUSED_TOP] = 1'b0;
      status_byte[s][BIT_PWR] = socket_power_on_flag_q[s];
      status_byte[s][BIT_READY] = pin_sync[s][PIN_READY];
      status_byte[s][BIT_WP] = pin_sync[s][PIN_WP];
      status_byte[s][BIT_CD2] = !pin_sync[s][PIN_CD2N];
      status_byte[s][BIT_CD1] = !pin_sync[s][PIN_CD1N];
      status_byte[s][BIT_BVD2] = pin_sync[s][PIN_BVD2];
      status_byte[s][BIT_BVD1] = pin_sync[s][PIN_BVD1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  always_comb begin
    dec_hit = 1'b0;
    dec_sock = 1'b0;
    dec_loc = reg_addr[5:0];
    dec_kind = KIND_NONE;
    if (reg_addr[11:6] == SOCK_B_BASE) begin
      dec_hit = 1'b1;
      dec_sock = 1'b1;
    end else if (reg_addr[11:6] == BANK_BASE) begin
      dec_hit = 1'b1;
    end
    if (dec_hit) begin
      if (dec_loc == LOC_STATUS) begin
        dec_kind = KIND_STATUS;
      end else if (dec_loc == LOC_PWR) begin
        dec_kind = KIND_PWR;
      end else if (dec_loc[2:0] == LOC_WIN_HI && int'(dec_loc[5:3]) < NWIN) begin
        dec_kind = KIND_WIN;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power control bytes; status writes fall through untouched

  always_comb begin
    pwr_d = pwr_q;
    for (int s = 0; s < SOCKETS; s++) begin
      if (reg_req && reg_wr && dec_kind == KIND_PWR && dec_sock == 1'(s)) begin
        pwr_d[s] = reg_wdata & PWR_WR_MASK;
      end
      pwr_on_d[s] = (pwr_d[s][VCC_MSB:VCC_LSB] == VCC_5V) ||
                    (pwr_d[s][VCC_MSB:VCC_LSB] == VCC_3V3);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window byte banks

  for (genvar s = 0; s < SOCKETS; s++) begin : g_sock
    pcss_win_if #(.NWIN(NWIN)) wif ();
    assign wif.wr_en = reg_req && reg_wr && dec_kind == KIND_WIN && dec_sock == 1'(s);
    assign wif.wr_idx = reg_addr[WIN_IDX_LSB +: WIN_IDX_W];
    assign wif.wr_data = reg_wdata;
    assign wif.rd_idx = reg_addr[WIN_IDX_LSB +: WIN_IDX_W];
    assign win_rd[s] = wif.rd_data;
    assign wp_all[s] = wif.wp_vec;
    pcss_win_bank #(.NWIN(NWIN)) u_bank (
      .mclk(mclk),
      .rst(rst),
      .bus(wif.bank)
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage read pipeline

  always_comb begin
    p1_valid_d = reg_req;
    p1_rd_d = reg_req && !reg_wr;
    p1_kind_d = dec_kind;
    p1_sock_d = dec_sock;
    p1_stat_d = status_byte[dec_sock];
    p1_pwr_d = pwr_q[dec_sock];
    ack_d = p1_valid_q;
    rdata_d = RD_UNMAPPED;
    if (p1_rd_q) begin
      case (p1_kind_q)
        KIND_STATUS: rdata_d = p1_stat_q;
        KIND_PWR: rdata_d = p1_pwr_q;
        KIND_WIN: rdata_d = win_rd[p1_sock_q];
        default: rdata_d = RD_UNMAPPED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write-protect check for card memory writes

  always_comb begin
    win_ok = int'(mem_wr_win) < NWIN;
    win_wp = 1'b0;
    if (win_ok) begin
      win_wp = wp_all[mem_wr_sock][mem_wr_win];
    end
    mem_ok_d = mem_wr_req && win_ok && !win_wp;
    mem_blk_d = mem_wr_req && !(win_ok && !win_wp);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers

  always_ff @(posedge mclk) begin
    if (rst) begin
      pwr_q <= {SOCKETS{REG_RST}};
      socket_power_on_flag_q <= '0;
      p1_valid_q <= 1'b0;
      p1_rd_q <= 1'b0;
      p1_kind_q <= KIND_NONE;
      p1_sock_q <= 1'b0;
      p1_stat_q <= REG_RST;
      p1_pwr_q <= REG_RST;
      reg_rdata_q <= RD_UNMAPPED;
      reg_ack_q <= 1'b0;
      mem_wr_ok_q <= 1'b0;
      mem_wr_blocked_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      socket_power_on_flag_q <= pwr_on_d;
      p1_valid_q <= p1_valid_d;
      p1_rd_q <= p1_rd_d;
      p1_kind_q <= p1_kind_d;
      p1_sock_q <= p1_sock_d;
      p1_stat_q <= p1_stat_d;
      p1_pwr_q <= p1_pwr_d;
      reg_rdata_q <= rdata_d;
      reg_ack_q <= ack_d;
      mem_wr_ok_q <= mem_ok_d;
      mem_wr_blocked_q <= mem_blk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_top_bit_zero: assert property (
    reg_req && !reg_wr && (reg_addr == OFS_STATUS_A || reg_addr == OFS_STATUS_B)
    |-> ##2 reg_ack_q && !reg_rdata_q[BIT_UNUSED_TOP])
    else $error("status top bit read as one");

  a_status_wr_ignored: assert property (
    reg_req && reg_wr && reg_addr == OFS_STATUS_A
    |=> $stable(pwr_q) && $stable(wp_all) ##1 reg_ack_q)
    else $error("status write changed state");

  a_reset_upper_zero: assert property (
    $fell(rst) |-> status_byte[0][7:6] == 2'b00 && status_byte[1][7:6] == 2'b00)
    else $error("upper status bits set after reset");

  a_sock_b_copy: assert property (
    reg_req && !reg_wr && reg_addr == OFS_STATUS_B
    |-> ##2 reg_ack_q && reg_rdata_q == $past(status_byte[1], 2))
    else $error("second socket status read wrong");

  a_sock_a_copy: assert property (
    reg_req && !reg_wr && reg_addr == OFS_STATUS_A
    |-> ##2 reg_rdata_q == $past(status_byte[0], 2))
    else $error("first socket status read wrong");

  a_pwr_on_bit: assert property (
    reg_req && reg_wr && reg_addr == PWR_A && reg_wdata[VCC_MSB:VCC_LSB] == VCC_3V3
    |=> status_byte[0][BIT_PWR] && socket_power_on_flag_q[0])
    else $error("power bit not set after supply on");

  a_pwr_off_bit: assert property (
    reg_req && reg_wr && reg_addr == PWR_A && reg_wdata[VCC_MSB:VCC_LSB] == VCC_OFF
    |=> !status_byte[0][BIT_PWR])
    else $error("power bit set after supply off");

  a_ready_follow: assert property (
    status_byte[0][BIT_READY] == $past(card_ready[0], 2))
    else $error("ready bit does not follow pin");

  a_wp_follow: assert property (
    status_byte[1][BIT_WP] == $past(card_wp[1], 2))
    else $error("write protect bit does not follow pin");

  a_win_block: assert property (
    reg_req && reg_wr && reg_addr == WIN0_HI_A && reg_wdata[WIN_WP_BIT]
    ##1 mem_wr_req && !mem_wr_sock && mem_wr_win == '0
    |=> mem_wr_blocked_q && !mem_wr_ok_q)
    else $error("write through protected window passed");

  a_win_pass: assert property (
    mem_wr_req && int'(mem_wr_win) < NWIN && !wp_all[mem_wr_sock][mem_wr_win]
    |=> mem_wr_ok_q && !mem_wr_blocked_q)
    else $error("write through open window blocked");

  a_detect_invert: assert property (
    status_byte[1][BIT_CD2] == !$past(card_cd2_n[1], 2) &&
    status_byte[1][BIT_CD1] == !$past(card_cd1_n[1], 2))
    else $error("card detect bits not inverted pins");

  a_battery_pair: assert property (
    status_byte[0][BIT_BVD2] == $past(card_bvd2[0], 2) &&
    status_byte[0][BIT_BVD1] == $past(card_bvd1[0], 2))
    else $error("battery field does not follow pins");

  a_unmapped_zero: assert property (
    reg_req && !reg_wr && reg_addr[11:6] != BANK_BASE && reg_addr[11:6] != SOCK_B_BASE
    |-> ##2 reg_ack_q && reg_rdata_q == RD_UNMAPPED)
    else $error("unmapped read not zero");
endmodule

// ### pcss_card_model.sv
// Behavioural 16-bit card pair that sets the socket pin levels
`timescale 1ns/1ps
module pcss_card_model (
  input wire logic mclk,
  input wire logic ld,
  input wire logic ld_sock,
  input wire logic [5:0] ld_val,
  input wire logic io_mode,
  output logic [1:0] card_ready,
  output logic [1:0] card_wp,
  output logic [1:0] card_cd1_n,
  output logic [1:0] card_cd2_n,
  output logic [1:0] card_bvd1,
  output logic [1:0] card_bvd2
);
  logic [5:0] pin_q [2] = '{6'h0C, 6'h0C};
  logic spkr_q = 1'b0;

  // Empty socket: pull-ups take every line high
  function automatic logic [5:0] drv(input logic [5:0] p, input logic io, input logic spk);
    if (p[3:2] == 2'h3) return 6'h3F;
    return io ? {spk, p[4:0]} : p;
  endfunction

  // I/O card speaker line toggles every cycle
  always @(posedge mclk) begin
    spkr_q <= ~spkr_q;
    if (ld) pin_q[ld_sock] <= ld_val;
  end

  assign {card_bvd2[0], card_bvd1[0], card_cd2_n[0], card_cd1_n[0], card_wp[0], card_ready[0]} =
    drv(pin_q[0], io_mode, spkr_q);
  assign {card_bvd2[1], card_bvd1[1], card_cd2_n[1], card_cd1_n[1], card_wp[1], card_ready[1]} =
    drv(pin_q[1], io_mode, spkr_q);
endmodule

// ### tb_pc_card_socket_status_reg.sv
// Self-checking bench for the two-socket interface status bank
`timescale 1ns/1ps
module tb_pc_card_socket_status_reg;
  import pcss_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic reg_req = 1'b0, reg_wr = 1'b0, mem_wr_req = 1'b0, mem_wr_sock = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 12'h000;
  logic [DATA_W-1:0] reg_wdata = 8'h00, reg_rdata_q;
  logic [WIN_IDX_W-1:0] mem_wr_win = 3'h0;
  logic reg_ack_q, mem_wr_ok_q, mem_wr_blocked_q;
  logic [1:0] card_ready, card_wp, card_cd1_n, card_cd2_n, card_bvd1, card_bvd2, pwr_q;
  logic ld = 1'b0, ld_sock = 1'b0, io_mode = 1'b0;
  logic [5:0] ld_val = 6'h0C;
  logic n_rq = 1'b0, n_wr = 1'b0, n_mq = 1'b0, n_ms = 1'b0, n_ld = 1'b0, n_ls = 1'b0, n_io = 1'b0;
  logic [11:0] n_a = 12'h000;
  logic [7:0] n_d = 8'h00;
  logic [2:0] n_mw = 3'h0;
  logic [5:0] n_lv = 6'h0C;
  int n_mismatch = 0, checked = 0, seed = 74, cyc = 0;
  logic [7:0] pwr_m [2], win_m [2][8], ed [4];
  logic [5:0] ph0 [2], ph1 [2], ph2 [2];
  logic ev [4];
  logic [1:0] me [4];
  logic [5:0] offs [9] = '{6'h01, 6'h02, 6'h05, 6'h0D, 6'h15, 6'h1D, 6'h25, 6'h2D, 6'h3F};

  always #5 mclk = ~mclk;

  pcss_status_top #(.NWIN(NUM_WIN)) DUT (.mclk(mclk), .rst(rst), .reg_req(reg_req),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_ack_q(reg_ack_q), .card_ready(card_ready), .card_wp(card_wp),
    .card_cd1_n(card_cd1_n), .card_cd2_n(card_cd2_n), .card_bvd1(card_bvd1),
    .card_bvd2(card_bvd2), .mem_wr_req(mem_wr_req), .mem_wr_sock(mem_wr_sock),
    .mem_wr_win(mem_wr_win), .mem_wr_ok_q(mem_wr_ok_q), .mem_wr_blocked_q(mem_wr_blocked_q),
    .socket_power_on_flag_q(pwr_q));

  pcss_card_model card (.mclk(mclk), .ld(ld), .ld_sock(ld_sock), .ld_val(ld_val),
    .io_mode(io_mode), .card_ready(card_ready), .card_wp(card_wp), .card_cd1_n(card_cd1_n),
    .card_cd2_n(card_cd2_n), .card_bvd1(card_bvd1), .card_bvd2(card_bvd2));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic pw(input int s);
    return pwr_m[s][4:3] == VCC_5V || pwr_m[s][4:3] == VCC_3V3;
  endfunction

  function automatic logic [7:0] rd(input logic [11:0] a);
    int s;
    s = a[6];
    if (a[11:7] != 5'h10) return 8'h00;
    if (a[5:0] == 6'h01) return {1'b0, pw(s), ph2[s][0], ph2[s][1], ~ph2[s][3], ~ph2[s][2],
      ph2[s][5], ph2[s][4]};
    if (a[5:0] == 6'h02) return pwr_m[s];
    if (a[2:0] == 3'h5 && a[5:3] < NUM_WIN) return win_m[s][a[5:3]];
    return 8'h00;
  endfunction

  // Reference model, sampled with pre-edge values
  always @(posedge mclk) begin
    logic blk;
    int s;
    cyc++;
    for (int k = 0; k < 2; k++) begin
      ph2[k] = ph1[k];
      ph1[k] = ph0[k];
      ph0[k] = {card_bvd2[k], card_bvd1[k], card_cd2_n[k], card_cd1_n[k], card_wp[k], card_ready[k]};
    end
    if (rst) begin
      for (int k = 0; k < 4; k++) begin
        ev[k] = 1'b0;
        ed[k] = 8'h00;
        me[k] = 2'h0;
      end
      for (int k = 0; k < 16; k++) win_m[k / 8][k % 8] = 8'h00;
      pwr_m = '{8'h00, 8'h00};
    end else begin
      check({7'h00, reg_ack_q}, {7'h00, ev[(cyc + 2) % 4]});
      check(reg_rdata_q, ed[(cyc + 2) % 4]);
      check({6'h00, mem_wr_ok_q, mem_wr_blocked_q}, {6'h00, me[(cyc + 3) % 4]});
      check({6'h00, pwr_q}, {6'h00, pw(1), pw(0)});
      ev[cyc % 4] = reg_req;
      ed[cyc % 4] = (reg_req && !reg_wr) ? rd(reg_addr) : 8'h00;
      blk = mem_wr_win >= NUM_WIN || win_m[mem_wr_sock][mem_wr_win][7];
      me[cyc % 4] = mem_wr_req ? {~blk, blk} : 2'h0;
      s = reg_addr[6];
      if (reg_req && reg_wr && reg_addr[11:7] == 5'h10) begin
        if (reg_addr[5:0] == 6'h02) pwr_m[s] = reg_wdata & PWR_WR_MASK;
        else if (reg_addr[2:0] == 3'h5 && reg_addr[5:3] < NUM_WIN)
          win_m[s][reg_addr[5:3]] = reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge mclk);
    reg_req <= n_rq;
    reg_wr <= n_wr;
    reg_addr <= n_a;
    reg_wdata <= n_d;
    mem_wr_req <= n_mq;
    mem_wr_sock <= n_ms;
    mem_wr_win <= n_mw;
    ld <= n_ld;
    ld_sock <= n_ls;
    ld_val <= n_lv;
    io_mode <= n_io;
    n_rq = 1'b0;
    n_mq = 1'b0;
    n_ld = 1'b0;
  endtask

  task automatic rw(input int wr, input int s, input logic [5:0] off, input logic [7:0] d);
    n_rq = 1'b1;
    n_wr = wr[0];
    n_a = {5'h10, s[0], off};
    n_d = d;
    tick();
  endtask

  task automatic pins(input int s, input logic [5:0] v);
    n_ld = 1'b1;
    n_ls = s[0];
    n_lv = v;
  endtask

  task automatic mw(input int s, input int w);
    n_mq = 1'b1;
    n_ms = s[0];
    n_mw = w[2:0];
    tick();
  endtask

  task automatic endt(input string name);
    repeat (4) tick();
    $display("test %s done", name);
  endtask

  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] r;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    for (int k = 0; k < 18; k++) rw(0, k / 9, offs[k % 9], 8'h00);
    endt("reset");
    // Pin changes overlap back-to-back reads
    for (int m = 0; m < 2; m++) begin
      n_io = m[0];
      for (int v = 0; v < 64; v++) begin
        pins(0, v[5:0]);
        rw(0, 0, 6'h01, 8'h00);
        pins(1, ~v[5:0]);
        rw(0, 1, 6'h01, 8'h00);
      end
    end
    endt("pins");
    for (int k = 0; k < 8; k++) begin
      r = 8'($random(seed));
      rw(1, k % 2, 6'h02, {r[7:5], k[2:1], r[2:0]});
      rw(1, k % 2, 6'h01, 8'hFF);
      rw(0, k % 2, 6'h01, 8'h00);
      rw(0, k % 2, 6'h02, 8'h00);
    end
    endt("power");
    for (int k = 0; k < 10; k++) begin
      r = 8'($random(seed));
      rw(1, k / 5, {k[2:0] % 3'h5, 3'h5}, {k[0], r[6:0]});
      mw(k / 5, k % 5);
    end
    // Protect window 0 of socket A, then write through it at once
    rw(1, 0, 6'h05, 8'h80);
    mw(0, 0);
    for (int k = 0; k < 16; k++) mw(k / 8, k % 8);
    endt("windows");
    rw(1, 0, 6'h3F, 8'hAA);
    rw(0, 0, 6'h3F, 8'h00);
    n_a = 12'h001;
    n_rq = 1'b1;
    tick();
    endt("unmapped");
    for (int k = 0; k < 600; k++) begin
      r = 8'($random(seed));
      n_rq = r[0];
      n_wr = r[1];
      n_mq = r[2];
      n_ld = r[3];
      n_ls = r[4];
      n_ms = r[5];
      n_io = r[6];
      n_mw = 3'($random(seed));
      n_lv = 6'($random(seed));
      n_d = 8'($random(seed));
      n_a = {5'h10, r[7], offs[$unsigned($random(seed)) % 9]};
      tick();
      if (k == 300) begin
        @(posedge mclk);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
      end
    end
    endt("random");
    summarize();
  end
endmodule
